/* File: hdl/pfm_pkg.sv */
package pfm_pkg;

  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam int unsigned ADDR_W         = 8;
  localparam logic [7:0]  OFS_SETTING    = 8'h00;
  localparam logic [7:0]  OFS_CONTROL    = 8'h04;
  localparam logic [7:0]  OFS_STATUS     = 8'h08;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int unsigned CTRL_ENABLE_BIT  = 0;
  localparam int unsigned STAT_ACTIVE_BIT  = 0;
  localparam int unsigned STAT_LEVEL_BIT   = 1;
  localparam int unsigned STAT_PENDING_BIT = 2;
  localparam int unsigned WIDTH_BYTE       = 2;
  localparam int unsigned INV_BIT          = 7;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [31:0] SETTING_RESET  = 32'h0000_0000;
  localparam logic        ENABLE_RESET   = 1'b0;
  localparam logic [2:0]  PRESC_RESET    = 3'h0;
  localparam logic [15:0] COUNT_RESET    = 16'h0000;
  localparam logic [31:0] RDATA_RESET    = 32'h0000_0000;

  // ---------------------------------------------------------------
  // timing: bus answers with no wait state
  // ---------------------------------------------------------------
  localparam int unsigned APB_WAIT_CYCLES = 0;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic        output_invert_flag;
    logic [6:0]  rsvd;
    logic [7:0]  width;
    logic [15:0] period;
  } pfm_setting_t;

  typedef struct packed {
    logic                psel;
    logic                penable;
    logic                pwrite;
    logic [ADDR_W-1:0]   paddr;
    logic [31:0]         pwdata;
    logic [3:0]          pstrb;
  } pfm_apb_req_t;

  typedef enum logic [1:0] {
    REG_SETTING = 2'b00,
    REG_CONTROL = 2'b01,
    REG_STATUS  = 2'b10,
    REG_NONE    = 2'b11
  } pfm_reg_t;

endpackage : pfm_pkg

/* File: hdl/pfm_channel.sv */
`timescale 1ns/100ps
module pfm_channel (
  input  wire logic        CORE_CLK,
  input  wire logic        RESETN,
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  input  wire logic [3:0]  PSTRB,
  output logic             PREADY,
  output logic [31:0]      PRDATA,
  output logic             PSLVERR,
  input  wire logic [1:0]  COUNTER_CLOCK_SELECT,
  output logic             PULSE_FREQ_CHANNEL
);

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic pfm_pkg::pfm_reg_t pfm_decode(input logic [7:0] addr);
    pfm_pkg::pfm_reg_t r;
    r = pfm_pkg::REG_NONE;
    if (addr == pfm_pkg::OFS_SETTING) begin
      r = pfm_pkg::REG_SETTING;
    end else if (addr == pfm_pkg::OFS_CONTROL) begin
      r = pfm_pkg::REG_CONTROL;
    end else if (addr == pfm_pkg::OFS_STATUS) begin
      r = pfm_pkg::REG_STATUS;
    end
    return r;
  endfunction : pfm_decode

  // width counter runs for the low part, so zero flag lasts width ticks
  function automatic logic [15:0] pfm_width_load(input pfm_pkg::pfm_setting_t s);
    logic [15:0] w;
    w = {8'h00, s.width};
    if (s.width == 8'h00) begin
      pfm_width_load = s.period | 16'h0001;
    end else if (w >= s.period) begin
      pfm_width_load = pfm_pkg::COUNT_RESET;
    end else begin
      pfm_width_load = s.period - w;
    end
  endfunction : pfm_width_load

  function automatic logic [7:0] pfm_merge(input logic [7:0] old_b,
                                           input logic [7:0] new_b,
                                           input logic       strb);
    return strb ? new_b : old_b;
  endfunction : pfm_merge

  // ---------------------------------------------------------------
  // apb decode
  // ---------------------------------------------------------------
  pfm_pkg::pfm_apb_req_t req;
  pfm_pkg::pfm_reg_t     sel_reg;
  logic                  wr_en;
  logic                  setup;

  assign req.psel    = PSEL;
  assign req.penable = PENABLE;
  assign req.pwrite  = PWRITE;
  assign req.paddr   = PADDR;
  assign req.pwdata  = PWDATA;
  assign req.pstrb   = PSTRB;

  assign sel_reg = pfm_decode(req.paddr);
  assign wr_en   = req.psel && req.penable && req.pwrite;
  assign setup   = req.psel && !req.penable;
  assign PREADY  = 1'b1;
  assign PSLVERR = req.psel && req.penable && (sel_reg == pfm_pkg::REG_NONE);

  // ---------------------------------------------------------------
  // setting storage
  // ---------------------------------------------------------------
  pfm_pkg::pfm_setting_t staged_q;
  pfm_pkg::pfm_setting_t staged_d;
  pfm_pkg::pfm_setting_t cfg_q;
  logic                  pending_q;
  logic                  set_wr;

  assign set_wr = wr_en && (sel_reg == pfm_pkg::REG_SETTING);

  always_comb begin
    staged_d = staged_q;
    for (int b = 0; b < 4; b++) begin
      staged_d[8*b +: 8] = pfm_merge(staged_q[8*b +: 8], req.pwdata[8*b +: 8],
                                     req.pstrb[b]);
    end
  end

  // staging keeps byte writes from tearing a running cycle
  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) begin
      staged_q <= pfm_pkg::SETTING_RESET;
      cfg_q    <= pfm_pkg::SETTING_RESET;
    end else if (set_wr) begin
      staged_q <= staged_d;
      if (req.pstrb[pfm_pkg::WIDTH_BYTE]) begin
        cfg_q <= staged_d;
      end
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) begin
      pending_q <= 1'b0;
    end else if (set_wr) begin
      pending_q <= !req.pstrb[pfm_pkg::WIDTH_BYTE];
    end
  end

  // ---------------------------------------------------------------
  // control
  // ---------------------------------------------------------------
  logic enable_q;
  logic en_prev_q;
  logic start;

  // only enable lives here; settings are untouched by standby
  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) begin
      enable_q <= pfm_pkg::ENABLE_RESET;
    end else if (wr_en && sel_reg == pfm_pkg::REG_CONTROL &&
                 req.pstrb[0]) begin
      enable_q <= req.pwdata[pfm_pkg::CTRL_ENABLE_BIT];
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) begin
      en_prev_q <= 1'b0;
    end else begin
      en_prev_q <= enable_q;
    end
  end

  assign start = enable_q && !en_prev_q;

  // ---------------------------------------------------------------
  // counter clock: strap option, divides core clock by 1,2,4,8
  // ---------------------------------------------------------------
  logic [1:0] csel_s1_q;
  logic [1:0] csel_s2_q;
  logic [2:0] presc_q;
  logic [2:0] presc_mask;
  logic       tick;

  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) begin
      csel_s1_q <= 2'h0;
      csel_s2_q <= 2'h0;
    end else begin
      csel_s1_q <= COUNTER_CLOCK_SELECT;
      csel_s2_q <= csel_s1_q;
    end
  end

  assign presc_mask = 3'((4'h1 << csel_s2_q) - 4'h1);
  // tick is the only time base, so cpu clock modes do not matter
  assign tick = enable_q && !start &&
                ((presc_q & presc_mask) == presc_mask);

  always_ff @(posedge CORE_CLK) begin
    if (!RESETN || !enable_q) begin
      presc_q <= pfm_pkg::PRESC_RESET;
    end else begin
      presc_q <= 3'(presc_q + 3'h1);
    end
  end

  // ---------------------------------------------------------------
  // counters
  // ---------------------------------------------------------------
  logic [15:0] per_q;
  logic [15:0] wid_q;
  logic        reload;
  logic        zero;

  assign reload = tick && (per_q <= 16'h0001);
  assign zero   = (wid_q == 16'h0000);

  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) begin
      per_q <= pfm_pkg::COUNT_RESET;
    end else if (start || reload) begin
      per_q <= cfg_q.period;
    end else if (tick) begin
      per_q <= per_q - 16'h0001;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) begin
      wid_q <= pfm_pkg::COUNT_RESET;
    end else if (start || reload) begin
      wid_q <= pfm_width_load(cfg_q);
    end else if (tick && !zero) begin
      wid_q <= wid_q - 16'h0001;
    end
  end

  // ---------------------------------------------------------------
  // output
  // ---------------------------------------------------------------
  logic out_q;

  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) begin
      out_q <= 1'b0;
    end else if (!enable_q || start) begin
      out_q <= cfg_q.output_invert_flag;
    end else begin
      out_q <= zero ^ cfg_q.output_invert_flag;
    end
  end

  assign PULSE_FREQ_CHANNEL = out_q;

  // ---------------------------------------------------------------
  // read data, captured in setup phase
  // ---------------------------------------------------------------
  logic [31:0] rdata_q;
  logic [31:0] rdata_d;

  always_comb begin
    rdata_d = pfm_pkg::RDATA_RESET;
    unique case (sel_reg)
      pfm_pkg::REG_CONTROL: rdata_d[pfm_pkg::CTRL_ENABLE_BIT] = enable_q;
      pfm_pkg::REG_STATUS: begin
        rdata_d[pfm_pkg::STAT_ACTIVE_BIT]  = en_prev_q;
        rdata_d[pfm_pkg::STAT_LEVEL_BIT]   = out_q;
        rdata_d[pfm_pkg::STAT_PENDING_BIT] = pending_q;
      end
      pfm_pkg::REG_SETTING: rdata_d = pfm_pkg::RDATA_RESET;
      pfm_pkg::REG_NONE:    rdata_d = pfm_pkg::RDATA_RESET;
    endcase
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) begin
      rdata_q <= pfm_pkg::RDATA_RESET;
    end else if (setup && !req.pwrite) begin
      rdata_q <= rdata_d;
    end
  end

  assign PRDATA = rdata_q;

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  property p_start_load;
    @(posedge CORE_CLK) disable iff (!RESETN)
    start |=> (per_q == $past(cfg_q.period)) && (wid_q == $past(pfm_width_load(cfg_q)));
  endproperty
  a_start_load: assert property (p_start_load)
    else $error("counters not loaded together on start");

  property p_zero_holds;
    @(posedge CORE_CLK) disable iff (!RESETN)
    (enable_q && zero && !reload && !start) |=> zero;
  endproperty
  a_zero_holds: assert property (p_zero_holds)
    else $error("width counter left zero without reload");

  property p_reload;
    @(posedge CORE_CLK) disable iff (!RESETN)
    (reload && !start) |=> (per_q == $past(cfg_q.period)) &&
                           (wid_q == $past(pfm_width_load(cfg_q)));
  endproperty
  a_reload: assert property (p_reload)
    else $error("period end did not reload both counters");

  property p_polarity;
    @(posedge CORE_CLK) disable iff (!RESETN)
    (enable_q && !start) |=> (PULSE_FREQ_CHANNEL == ($past(zero) ^ $past(cfg_q.output_invert_flag)));
  endproperty
  a_polarity: assert property (p_polarity)
    else $error("output does not follow zero flag and invert");

  property p_reset_low;
    @(posedge CORE_CLK) disable iff (!RESETN)
    $rose(RESETN) |-> (!PULSE_FREQ_CHANNEL && !enable_q);
  endproperty
  a_reset_low: assert property (p_reset_low)
    else $error("not in standby with low output after reset");

  property p_partial;
    @(posedge CORE_CLK) disable iff (!RESETN)
    (set_wr && !req.pstrb[pfm_pkg::WIDTH_BYTE]) |=> $stable(cfg_q);
  endproperty
  a_partial: assert property (p_partial)
    else $error("setting committed without width byte");

  property p_standby_out;
    @(posedge CORE_CLK) disable iff (!RESETN)
    !enable_q |=> (PULSE_FREQ_CHANNEL == $past(cfg_q.output_invert_flag)) && (presc_q == 3'h0);
  endproperty
  a_standby_out: assert property (p_standby_out)
    else $error("standby output not at invert level");

  property p_keep;
    @(posedge CORE_CLK) disable iff (!RESETN)
    (!enable_q && !set_wr) |=> $stable(cfg_q) && $stable(staged_q);
  endproperty
  a_keep: assert property (p_keep)
    else $error("standby changed stored setting");

  property p_no_readback;
    @(posedge CORE_CLK) disable iff (!RESETN)
    (PSEL && PENABLE && !PWRITE && sel_reg == pfm_pkg::REG_SETTING) |-> (PRDATA == 32'h0);
  endproperty
  a_no_readback: assert property (p_no_readback)
    else $error("setting register read back nonzero");

  property p_decrement;
    @(posedge CORE_CLK) disable iff (!RESETN)
    (tick && !reload && !zero) |=> (wid_q == $past(wid_q) - 16'h1) &&
                                   (per_q == $past(per_q) - 16'h1);
  endproperty
  a_decrement: assert property (p_decrement)
    else $error("counters did not decrement by one");

  // width of the running cycle; a mid-cycle write does not count yet
  logic [7:0] run_width_q;

  always_ff @(posedge CORE_CLK) begin
    if (!RESETN) begin
      run_width_q <= 8'h00;
    end else if (start || reload) begin
      run_width_q <= cfg_q.width;
    end
  end

  property p_width_zero;
    @(posedge CORE_CLK) disable iff (!RESETN)
    (enable_q && !start && run_width_q == 8'h00) |=> (PULSE_FREQ_CHANNEL == $past(cfg_q.output_invert_flag));
  endproperty
  a_width_zero: assert property (p_width_zero)
    else $error("zero width not constant at invert level");

endmodule : pfm_channel

/* File: sim/pfm_lcd_pump.sv */
`timescale 1ns/100ps
// ---------------------------------------------------------------
// charge pump stage seen by the pin
// ---------------------------------------------------------------
module pfm_lcd_pump (
  input  wire logic        clk,
  input  wire logic        drive,
  output logic [15:0]      hi_len,
  output logic [15:0]      lo_len
);
  // the pump only reacts to run lengths of its drive level
  logic [15:0] run_q;
  logic        last_q;
  initial begin
    run_q  = 16'h0000;
    last_q = 1'b0;
    hi_len = 16'h0000;
    lo_len = 16'h0000;
  end
  always @(posedge clk) begin
    if (drive !== last_q) begin
      if (last_q === 1'b1) hi_len <= run_q;
      else lo_len <= run_q;
      run_q <= 16'h0001;
    end else begin
      run_q <= run_q + 16'h0001;
    end
    last_q <= drive;
  end
endmodule : pfm_lcd_pump

/* File: sim/pulse_frequency_modulator_bench.sv */
`timescale 1ns/100ps
module pulse_frequency_modulator_bench;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, pin;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  pstrb;
  logic [1:0]  sel;
  logic [15:0] hi_len, lo_len;
  logic        err;
  int          fail_count, comparisons;
  // ---------------------------------------------------------------
  // design and pump
  // ---------------------------------------------------------------
  pfm_channel pfm_channel_inst (.CORE_CLK(clk), .RESETN(rst_n), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PSTRB(pstrb), .PREADY(pready), .PRDATA(prdata), .PSLVERR(pslverr),
    .COUNTER_CLOCK_SELECT(sel), .PULSE_FREQ_CHANNEL(pin));
  pfm_lcd_pump pfm_lcd_pump_inst (.clk(clk), .drive(pin), .hi_len(hi_len),
    .lo_len(lo_len));
  always #4 clk = ~clk;
  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task wrap_up;
    $display("checks %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up
  task chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // entered right after a rising edge; leaves one edge after release
  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
           input logic [3:0] s);
    int i;
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr;
    paddr <= a; pwdata <= d; pstrb <= s;
    @(posedge clk);
    penable <= 1'b1;
    for (i = 0; i < 16; i++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (i == 16) begin
      fail_count++;
      wrap_up();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge clk);
  endtask : apb
  function automatic logic [31:0] mk(input logic output_invert_flag, input logic [7:0] w,
                                     input logic [15:0] p);
    return {output_invert_flag, 7'h00, w, p};
  endfunction : mk
  // counts are derived from the pump, in core clocks
  task meas(input logic [15:0] h, input logic [15:0] l);
    repeat (3 * (h + l) + 8) @(posedge clk);
    chk("high run", {16'h0000, hi_len}, {16'h0000, h});
    chk("low run", {16'h0000, lo_len}, {16'h0000, l});
  endtask : meas
  task steady(input logic lvl);
    logic seen;
    repeat (40) @(posedge clk);
    seen = lvl;
    repeat (40) begin
      @(posedge clk);
      if (pin !== lvl) seen = pin;
    end
    chk("steady pin", {31'h0, seen}, {31'h0, lvl});
  endtask : steady
  initial begin
    repeat (100000) @(posedge clk);
    fail_count++;
    wrap_up();
  end
  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    clk = 0; rst_n = 0; psel = 0; penable = 0; pwrite = 0;
    paddr = 8'h00; pwdata = 32'h0000_0000; pstrb = 4'h0; sel = 2'h0;
    fail_count = 0; comparisons = 0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1 chk("pin after reset", {31'h0, pin}, 32'h0000_0000);
    @(posedge clk);
    apb(1'b0, pfm_pkg::OFS_SETTING, 32'h0000_0000, 4'h0);
    chk("setting read", rd, 32'h0000_0000);
    apb(1'b0, pfm_pkg::OFS_CONTROL, 32'h0000_0000, 4'h0);
    chk("control reset", rd, 32'h0000_0000);
    apb(1'b0, 8'h0C, 32'h0000_0000, 4'h0);
    chk("unmapped err", {31'h0, err}, 32'h0000_0001);
    $display("test reset done");
    // settings first, then enable
    apb(1'b1, pfm_pkg::OFS_SETTING, mk(1'b0, 8'h03, 16'h000A), 4'hF);
    apb(1'b1, pfm_pkg::OFS_CONTROL, 32'h0000_0001, 4'h1);
    apb(1'b0, pfm_pkg::OFS_STATUS, 32'h0000_0000, 4'h0);
    chk("active", {31'h0, rd[pfm_pkg::STAT_ACTIVE_BIT]}, 32'h0000_0001);
    meas(16'd3, 16'd7);
    apb(1'b1, pfm_pkg::OFS_SETTING, mk(1'b1, 8'h04, 16'h000C), 4'hF);
    meas(16'd8, 16'd4);
    apb(1'b0, pfm_pkg::OFS_SETTING, 32'h0000_0000, 4'h0);
    chk("setting hidden", rd, 32'h0000_0000);
    $display("test pulses done");
    // partial writes stay staged until the width byte arrives
    apb(1'b1, pfm_pkg::OFS_SETTING, 32'h0000_0014, 4'h3);
    apb(1'b0, pfm_pkg::OFS_STATUS, 32'h0000_0000, 4'h0);
    chk("pending", {31'h0, rd[pfm_pkg::STAT_PENDING_BIT]}, 32'h0000_0001);
    meas(16'd8, 16'd4);
    apb(1'b1, pfm_pkg::OFS_SETTING, 32'h0005_0000, 4'h4);
    meas(16'd15, 16'd5);
    $display("test partial done");
    apb(1'b1, pfm_pkg::OFS_CONTROL, 32'h0000_0000, 4'h1);
    @(posedge clk);
    #1 chk("disabled pin", {31'h0, pin}, 32'h0000_0001);
    steady(1'b1);
    apb(1'b1, pfm_pkg::OFS_CONTROL, 32'h0000_0001, 4'h1);
    meas(16'd15, 16'd5);
    $display("test standby done");
    apb(1'b1, pfm_pkg::OFS_SETTING, mk(1'b0, 8'h00, 16'h000A), 4'hF);
    steady(1'b0);
    apb(1'b1, pfm_pkg::OFS_SETTING, mk(1'b1, 8'h00, 16'h000A), 4'hF);
    steady(1'b1);
    apb(1'b1, pfm_pkg::OFS_SETTING, mk(1'b0, 8'h0A, 16'h000A), 4'hF);
    steady(1'b1);
    apb(1'b1, pfm_pkg::OFS_SETTING, mk(1'b1, 8'h0C, 16'h000A), 4'hF);
    steady(1'b0);
    $display("test limits done");
    // slower counter clock: divide by 2 doubles every run, divide by 8 makes every run eight times longer
    sel <= 2'h1;
    apb(1'b1, pfm_pkg::OFS_SETTING, mk(1'b0, 8'h03, 16'h000A), 4'hF);
    meas(16'd6, 16'd14);
    sel <= 2'h3;
    meas(16'd24, 16'd56);
    $display("test clock option done");
    // reset in mid-run drops back to standby with output low
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1 chk("pin after second reset", {31'h0, pin}, 32'h0000_0000);
    @(posedge clk);
    apb(1'b0, pfm_pkg::OFS_STATUS, 32'h0000_0000, 4'h0);
    chk("status after reset", rd, 32'h0000_0000);
    // cleared setting: zero width and zero period must stay at invert level
    apb(1'b1, pfm_pkg::OFS_CONTROL, 32'h0000_0001, 4'h1);
    steady(1'b0);
    $display("test second reset done");
    wrap_up();
  end
endmodule : pulse_frequency_modulator_bench
